// *** core/hml_top.sv ***
// Homing sequencer and software travel limit supervisor, APB slave.
// Assumes synchronous inputs, positions in units of 0.0001, and an
// outer profile generator that follows the move and end outputs.
`timescale 1ns/1ps
`default_nettype none
module hml_top #(
   parameter logic signed [31:0] INT_LIMIT = 32'sh7A120000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [31:0] actual_position,
   input wire logic zero_pulse,
   input wire logic positive_travel_switch_n,
   input wire logic negative_travel_switch_n,
   input wire logic homing_switch,
   input wire logic [3:0] probe_terminal,
   input wire logic absolute_accept_input,
   input wire logic abs_feedback_sel,
   input wire logic resolver_sel,
   input wire logic param_written,
   input wire logic speed_limit_fault,
   input wire logic encoder_limit_fault,
   input wire logic resolver_fault,
   input wire logic abs_encoder_fault,
   input wire logic positioning_active,
   input wire logic prog_reset_in,
   input wire logic signed [31:0] input_target_seventy,
   output logic fault_quick_stop,
   output logic limit_fault_pos,
   output logic limit_fault_neg,
   output logic limit_warning,
   output logic travel_fault,
   output logic ref_known,
   output logic homing_busy,
   output logic move_en,
   output logic move_dir_neg,
   output logic [31:0] homing_speed_out,
   output logic [31:0] homing_accel_out,
   output logic pos_load,
   output logic signed [31:0] pos_load_value,
   output logic end_valid,
   output logic signed [31:0] end_target
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic signed [31:0] clamp(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      if (v > hi) begin
         return hi;
      end else if (v < lo) begin
         return lo;
      end
      return v;
   endfunction

   function automatic logic in_rng(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [3:0] mode_reg;
   logic [6:0] end_reg;
   logic [2:0] src_reg;
   logic edge_reg;
   logic [1:0] pmode_reg;
   logic fitted_reg;
   logic signed [31:0] limp_reg;
   logic signed [31:0] limn_reg;
   logic signed [31:0] ofs_reg;
   logic signed [31:0] refp_reg;
   logic [31:0] hspd_reg;
   logic [31:0] hacc_reg;
   logic signed [31:0] t60_reg;
   logic signed [31:0] t100_reg;
   logic signed [31:0] aofs_reg;
   logic reject_reg;
   logic probe_prev_reg;
   logic dir_reg;
   hml_pkg::hml_state_t st_reg;

   logic acc, wr, rd_err;
   logic [31:0] rd_data;
   logic start, set_ref, prg_rst, clr;
   logic signed [31:0] effp, effn;
   logic signed [32:0] mpos;
   logic over_p, under_n;

   assign acc = psel & penable;
   assign wr = acc & pready & pwrite & ~pslverr;
   assign start = wr & (paddr == hml_pkg::A_CMD)
      & pwdata[hml_pkg::CMD_START];
   assign set_ref = wr & (paddr == hml_pkg::A_CMD)
      & pwdata[hml_pkg::CMD_SETREF];
   assign prg_rst = prog_reset_in | (wr & (paddr == hml_pkg::A_CMD)
      & pwdata[hml_pkg::CMD_PRGRST]);
   assign clr = wr & (paddr == hml_pkg::A_CMD)
      & pwdata[hml_pkg::CMD_CLR];

   // ------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // ------------------------------------------------------------
   always_comb begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      unique case (paddr)
         hml_pkg::A_CTRL: rd_data = {17'h00000, edge_reg, src_reg,
            end_reg, mode_reg};
         hml_pkg::A_CFG: rd_data = {29'h00000000, fitted_reg,
            pmode_reg};
         hml_pkg::A_CMD: rd_data = 32'h00000000;
         hml_pkg::A_STAT: rd_data = {25'h0000000, travel_fault,
            reject_reg, limit_warning, limit_fault_neg,
            limit_fault_pos, homing_busy, ref_known};
         hml_pkg::A_LIMP: begin
            rd_data = limp_reg;
            rd_err = pwrite & ~in_rng(pwdata, hml_pkg::ZERO32,
               hml_pkg::LIM_MAX);
         end
         hml_pkg::A_LIMN: begin
            rd_data = limn_reg;
            rd_err = pwrite & ~in_rng(pwdata, hml_pkg::LIM_MIN,
               hml_pkg::ZERO32);
         end
         hml_pkg::A_OFS: rd_data = ofs_reg;
         hml_pkg::A_REFP: rd_data = refp_reg;
         hml_pkg::A_HSPD: rd_data = hspd_reg;
         hml_pkg::A_HACC: rd_data = hacc_reg;
         hml_pkg::A_T60: rd_data = t60_reg;
         hml_pkg::A_T100: rd_data = t100_reg;
         hml_pkg::A_EFFP: rd_data = effp;
         hml_pkg::A_EFFN: rd_data = effn;
         hml_pkg::A_AOFS: rd_data = aofs_reg;
         hml_pkg::A_HPOS: rd_data = pos_load_value;
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         if (acc & ~pready) begin
            pready <= 1'b1;
            pslverr <= rd_err;
            prdata <= pwrite ? 32'h00000000 : rd_data;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= hml_pkg::MODE_RST;
         end_reg <= hml_pkg::END_HOME;
         src_reg <= hml_pkg::SRC_RST;
         edge_reg <= 1'b0;
         pmode_reg <= hml_pkg::PM_ABS;
         fitted_reg <= 1'b0;
         limp_reg <= hml_pkg::LIM_MAX;
         limn_reg <= hml_pkg::LIM_MIN;
         ofs_reg <= hml_pkg::ZERO32;
         refp_reg <= hml_pkg::ZERO32;
         hspd_reg <= 32'h00000000;
         hacc_reg <= 32'h00000000;
         t60_reg <= hml_pkg::ZERO32;
         t100_reg <= hml_pkg::ZERO32;
      end else if (ce && wr) begin
         unique case (paddr)
            hml_pkg::A_CTRL: begin
               mode_reg <= pwdata[hml_pkg::CTRL_MODE +: 4];
               end_reg <= pwdata[hml_pkg::CTRL_END +: 7];
               src_reg <= pwdata[hml_pkg::CTRL_SRC +: 3];
               edge_reg <= pwdata[hml_pkg::CTRL_EDGE];
            end
            hml_pkg::A_CFG: begin
               pmode_reg <= pwdata[hml_pkg::CFG_PMODE +: 2];
               fitted_reg <= pwdata[hml_pkg::CFG_FITTED];
            end
            hml_pkg::A_LIMP: limp_reg <= pwdata;
            hml_pkg::A_LIMN: limn_reg <= pwdata;
            hml_pkg::A_OFS: ofs_reg <= pwdata;
            hml_pkg::A_REFP: refp_reg <= pwdata;
            hml_pkg::A_HSPD: hspd_reg <= pwdata;
            hml_pkg::A_HACC: hacc_reg <= pwdata;
            hml_pkg::A_T60: t60_reg <= pwdata;
            hml_pkg::A_T100: t100_reg <= pwdata;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Software travel limits
   // ------------------------------------------------------------
   // The entered limits stay as written; only the working copy is cut.
   assign effp = clamp(limp_reg, hml_pkg::ZERO32, INT_LIMIT);
   assign effn = clamp(limn_reg, -INT_LIMIT, hml_pkg::ZERO32);
   // Positions refer to real zero; adding the offset gives machine zero.
   assign mpos = {actual_position[31], actual_position}
      + {aofs_reg[31], aofs_reg};
   // A concatenation is unsigned, so both sides are kept signed on purpose.
   assign over_p = mpos > $signed({effp[31], effp});
   assign under_n = mpos < $signed({effn[31], effn});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_fault_pos <= 1'b0;
         limit_fault_neg <= 1'b0;
         fault_quick_stop <= 1'b0;
         limit_warning <= 1'b0;
      end else if (ce) begin
         limit_fault_pos <= over_p | (limit_fault_pos & ~clr);
         limit_fault_neg <= under_n | (limit_fault_neg & ~clr);
         fault_quick_stop <= over_p | under_n
            | ((limit_fault_pos | limit_fault_neg) & ~clr);
         limit_warning <= (limp_reg > INT_LIMIT)
            | (limn_reg < -INT_LIMIT);
      end
   end

   // ------------------------------------------------------------
   // Touch probe
   // ------------------------------------------------------------
   logic probe_ok, probe_lvl, probe_ev, tsw_fwd, tsw_pos, tsw_neg;
   logic uses_probe, mark_ev, start_ok, end_ok, done;
   logic signed [31:0] home_val, end_val;

   assign probe_ok = (src_reg >= 3'h1) && (src_reg <= 3'h4);
   assign probe_lvl = probe_ok
      ? probe_terminal[2'(src_reg - 3'h1)] : 1'b0;
   assign probe_ev = edge_reg ? (probe_prev_reg & ~probe_lvl)
      : (~probe_prev_reg & probe_lvl);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         probe_prev_reg <= 1'b0;
      end else if (ce) begin
         probe_prev_reg <= probe_lvl;
      end
   end

   // ------------------------------------------------------------
   // Homing sequencer
   // ------------------------------------------------------------
   assign tsw_pos = ~positive_travel_switch_n;
   assign tsw_neg = ~negative_travel_switch_n;
   assign tsw_fwd = dir_reg ? tsw_neg : tsw_pos;
   assign uses_probe = mode_reg >= 4'h6;
   // Probe edges seen before the marking phase are never looked at.
   assign mark_ev = uses_probe ? probe_ev : zero_pulse;
   assign end_ok = (end_reg == hml_pkg::END_HOME)
      | (end_reg == hml_pkg::END_ZERO) | (end_reg == hml_pkg::END_T60)
      | (end_reg == hml_pkg::END_T70)
      | (end_reg == hml_pkg::END_T101);
   assign start_ok = (mode_reg <= hml_pkg::MODE_MAX) & end_ok
      & (~uses_probe | probe_ok)
      & (~(mode_reg[3:1] == 3'h1)
         | ((pmode_reg != hml_pkg::PM_REL) & fitted_reg));
   assign done = (st_reg == hml_pkg::S_MARK) & mark_ev;
   assign home_val = refp_reg + aofs_reg;

   always_comb begin
      unique case (end_reg)
         hml_pkg::END_ZERO: end_val = hml_pkg::ZERO32;
         hml_pkg::END_T60: end_val = t60_reg;
         hml_pkg::END_T70: end_val = input_target_seventy;
         hml_pkg::END_T101: end_val = t100_reg;
         default: end_val = home_val;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= hml_pkg::S_IDLE;
         dir_reg <= 1'b0;
         reject_reg <= 1'b0;
         travel_fault <= 1'b0;
      end else if (ce) begin
         reject_reg <= (start & ~start_ok)
            | (reject_reg & ~clr);
         travel_fault <= travel_fault & ~clr;
         unique case (st_reg)
            hml_pkg::S_IDLE: begin
               if (start & start_ok) begin
                  dir_reg <= mode_reg[0];
                  if (mode_reg[3:1] == 3'h1) begin
                     st_reg <= hml_pkg::S_TOSW;
                  end else if (mode_reg[3:1] == 3'h4) begin
                     st_reg <= hml_pkg::S_MARK;
                  end else begin
                     st_reg <= hml_pkg::S_SEEK;
                  end
               end
            end
            hml_pkg::S_TOSW: begin
               // Reaching the switch here is expected, not a fault.
               if (tsw_fwd) begin
                  dir_reg <= ~dir_reg;
                  st_reg <= hml_pkg::S_SEEK;
               end
            end
            hml_pkg::S_SEEK: begin
               if (homing_switch) begin
                  if (mode_reg[3:1] == 3'h2) begin
                     dir_reg <= ~dir_reg;
                  end
                  st_reg <= hml_pkg::S_CROSS;
               end else if (tsw_fwd) begin
                  if (mode_reg[3:1] == 3'h2) begin
                     dir_reg <= ~dir_reg;
                  end else begin
                     travel_fault <= 1'b1;
                     st_reg <= hml_pkg::S_IDLE;
                  end
               end
            end
            hml_pkg::S_CROSS: begin
               if (!homing_switch) begin
                  st_reg <= hml_pkg::S_MARK;
               end else if (tsw_fwd) begin
                  travel_fault <= 1'b1;
                  st_reg <= hml_pkg::S_IDLE;
               end
            end
            hml_pkg::S_MARK: begin
               if (mark_ev) begin
                  st_reg <= hml_pkg::S_IDLE;
               end else if (tsw_fwd) begin
                  travel_fault <= 1'b1;
                  st_reg <= hml_pkg::S_IDLE;
               end
            end
            default: st_reg <= hml_pkg::S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Motion and result outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aofs_reg <= hml_pkg::ZERO32;
         homing_busy <= 1'b0;
         move_en <= 1'b0;
         move_dir_neg <= 1'b0;
         homing_speed_out <= 32'h00000000;
         homing_accel_out <= 32'h00000000;
         pos_load <= 1'b0;
         pos_load_value <= hml_pkg::ZERO32;
         end_valid <= 1'b0;
         end_target <= hml_pkg::ZERO32;
      end else if (ce) begin
         if (start & start_ok & (st_reg == hml_pkg::S_IDLE)) begin
            aofs_reg <= ofs_reg;
         end
         homing_busy <= st_reg != hml_pkg::S_IDLE;
         move_en <= st_reg != hml_pkg::S_IDLE;
         move_dir_neg <= dir_reg;
         homing_speed_out <= hspd_reg;
         homing_accel_out <= hacc_reg;
         pos_load <= done;
         end_valid <= done;
         if (done) begin
            pos_load_value <= home_val;
            end_target <= end_val;
         end
      end
   end

   // ------------------------------------------------------------
   // Home known flag, set wins over clear
   // ------------------------------------------------------------
   logic rk_set, rk_clr;

   assign rk_set = done | set_ref | abs_feedback_sel
      | absolute_accept_input
      | (pmode_reg == hml_pkg::PM_SAVE);
   assign rk_clr = start | (wr & (paddr == hml_pkg::A_CFG))
      | param_written | speed_limit_fault | encoder_limit_fault
      | (resolver_fault & resolver_sel) | abs_encoder_fault
      | ((pmode_reg == hml_pkg::PM_REL) & prg_rst
         & positioning_active);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_known <= 1'b0;
      end else if (ce) begin
         ref_known <= rk_set | (ref_known & ~rk_clr);
      end
   end
endmodule // hml_top
`default_nettype wire

// *** core/hml_pkg.sv ***
// Package of the homing and travel limit block.
// Holds register offsets, field positions, reset values and states.
`default_nettype none
package hml_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CFG = 8'h04;
   localparam logic [7:0] A_CMD = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   localparam logic [7:0] A_LIMP = 8'h10;
   localparam logic [7:0] A_LIMN = 8'h14;
   localparam logic [7:0] A_OFS = 8'h18;
   localparam logic [7:0] A_REFP = 8'h1C;
   localparam logic [7:0] A_HSPD = 8'h20;
   localparam logic [7:0] A_HACC = 8'h24;
   localparam logic [7:0] A_T60 = 8'h28;
   localparam logic [7:0] A_T100 = 8'h2C;
   localparam logic [7:0] A_EFFP = 8'h30;
   localparam logic [7:0] A_EFFN = 8'h34;
   localparam logic [7:0] A_AOFS = 8'h38;
   localparam logic [7:0] A_HPOS = 8'h3C;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_MODE = 0;
   localparam int CTRL_END = 4;
   localparam int CTRL_SRC = 11;
   localparam int CTRL_EDGE = 14;
   localparam int CFG_PMODE = 0;
   localparam int CFG_FITTED = 2;
   localparam int CMD_START = 0;
   localparam int CMD_SETREF = 1;
   localparam int CMD_PRGRST = 2;
   localparam int CMD_CLR = 3;
   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [3:0] MODE_MAX = 4'h9;
   localparam logic [6:0] END_HOME = 7'h00;
   localparam logic [6:0] END_ZERO = 7'h01;
   localparam logic [6:0] END_T60 = 7'h3D;
   localparam logic [6:0] END_T70 = 7'h47;
   localparam logic [6:0] END_T101 = 7'h65;
   localparam logic [2:0] SRC_RST = 3'h4;
   localparam logic [1:0] PM_ABS = 2'h0;
   localparam logic [1:0] PM_REL = 2'h1;
   localparam logic [1:0] PM_SAVE = 2'h2;
   // Limits in units of 0.0001: 214000.0000 and -214000.0000.
   localparam logic signed [31:0] LIM_MAX = 32'sh7F8DCF00;
   localparam logic signed [31:0] LIM_MIN = 32'sh80723100;
   localparam logic signed [31:0] ZERO32 = 32'sh00000000;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_TOSW = 5'b00010,
      S_SEEK = 5'b00100,
      S_CROSS = 5'b01000,
      S_MARK = 5'b10000
   } hml_state_t;
endpackage
`default_nettype wire

// *** verif/hml_sva.sv ***
// Checker of the homing and travel limit block.
// Sees only ports of hml_top; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module hml_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic absolute_accept_input,
   input wire logic abs_feedback_sel,
   input wire logic speed_limit_fault,
   input wire logic limit_fault_pos,
   input wire logic limit_fault_neg,
   input wire logic fault_quick_stop,
   input wire logic ref_known,
   input wire logic homing_busy,
   input wire logic move_en,
   input wire logic pos_load,
   input wire logic end_valid
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_done;
      end_valid && ref_known ##1 !homing_busy && !move_en;
   endsequence
   a_apb_wait: assert property (s_setup |-> !pready ##1 pready)
      else $error("apb wait state wrong");
   a_err_pair: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_lim_stop: assert property (limit_fault_pos || limit_fault_neg
      |-> ##[0:1] fault_quick_stop) else $error("no quick stop");
   a_home_done: assert property (pos_load |-> s_done)
      else $error("homing end wrong");
   a_load_once: assert property (pos_load |=> !pos_load)
      else $error("load not a pulse");
   a_move_busy: assert property (move_en |-> homing_busy)
      else $error("move while idle");
   a_accept_set: assert property (absolute_accept_input |=> ref_known)
      else $error("accept did not set");
   a_fault_clr: assert property (speed_limit_fault && !abs_feedback_sel
      && !absolute_accept_input |=> !ref_known)
      else $error("fault did not clear");
endmodule // hml_sva
bind hml_top hml_sva u_sva (.*);
`default_nettype wire

// *** verif/hml_mech.sv ***
// Axle model: moves one unit per cycle while move_en is high.
// Homing switch at 300..400 and probe at 450..459 on both sides.
`timescale 1ns/1ps
`default_nettype none
module hml_mech (
   input wire logic pclk,
   input wire logic move_en,
   input wire logic move_dir_neg,
   input wire logic [1:0] probe_sel,
   output logic signed [31:0] actual_position,
   output logic zero_pulse,
   output logic positive_travel_switch_n,
   output logic negative_travel_switch_n,
   output logic homing_switch,
   output logic [3:0] probe_terminal
);
   logic signed [31:0] pos = 32'sh0;
   logic signed [31:0] mag;
   // The bench may also place the axle while it stands still.
   always @(posedge pclk)
      if (move_en) pos <= move_dir_neg ? pos - 1 : pos + 1;
   assign mag = pos < 0 ? -pos : pos;
   assign actual_position = pos;
   assign zero_pulse = pos[5:0] == 6'h00;
   assign positive_travel_switch_n = pos < 1000;
   assign negative_travel_switch_n = pos > -1000;
   assign homing_switch = mag >= 300 && mag <= 400;
   assign probe_terminal = (mag >= 450 && mag < 460) ?
      4'h1 << probe_sel : 4'h0;
endmodule // hml_mech
`default_nettype wire

// *** verif/homing_and_travel_limits_tb.sv ***
// Self-checking bench of the homing and travel limit block.
// Drives APB and control inputs; hml_mech plays the axle.
`timescale 1ns/1ps
`default_nettype none
module homing_and_travel_limits_tb;
   localparam logic signed [31:0] LIMI = 32'sh7A120000;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, homing_speed_out, homing_accel_out;
   logic pready, pslverr, zero_pulse, homing_switch, pos_load, end_valid;
   logic positive_travel_switch_n, negative_travel_switch_n;
   logic [3:0] probe_terminal;
   logic signed [31:0] actual_position, pos_load_value, end_target;
   logic fault_quick_stop, limit_fault_pos, limit_fault_neg, limit_warning;
   logic travel_fault, ref_known, homing_busy, move_en, move_dir_neg;
   logic absolute_accept_input = 1'b0;
   logic abs_feedback_sel = 1'b0;
   logic resolver_sel = 1'b1;
   logic positioning_active = 1'b0;
   logic prog_reset_in = 1'b0;
   logic signed [31:0] input_target_seventy = 32'sh0;
   logic [4:0] clr = 5'h00;
   wire logic speed_limit_fault = clr[0];
   wire logic encoder_limit_fault = clr[1];
   wire logic resolver_fault = clr[2];
   wire logic abs_encoder_fault = clr[3];
   wire logic param_written = clr[4];
   logic [15:0] lfsr = 16'h628D;
   logic [31:0] rd, t60, t101, refp, ofs;
   logic er;
   logic [2:0] src = 3'h1;
   logic [6:0] sel;
   int fail_count = 0;
   int total_checks = 0;
   int n;
   logic [6:0] ends [5] = '{hml_pkg::END_HOME, hml_pkg::END_ZERO,
      hml_pkg::END_T60, hml_pkg::END_T70, hml_pkg::END_T101};

   hml_top #(.INT_LIMIT(LIMI)) DUT (.*);
   hml_mech mech (.*, .probe_sel(src[1:0] - 2'h1));

   initial forever #2 pclk = ~pclk;

   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] exp_end(input logic [6:0] s,
      input logic [31:0] h);
      case (s)
         hml_pkg::END_ZERO: return 32'h0;
         hml_pkg::END_T60: return t60;
         hml_pkg::END_T70: return input_target_seventy;
         hml_pkg::END_T101: return t101;
         default: return h;
      endcase
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      lfsr = nx(lfsr);
      input_target_seventy <= {16'h0, lfsr};
      apb(1, hml_pkg::A_LIMP, hml_pkg::LIM_MAX + 1);
      chk(er, 1'b1);
      apb(1, hml_pkg::A_LIMN, 32'h1);
      chk(er, 1'b1);
      apb(0, hml_pkg::A_LIMP, 32'h0);
      chk(rd, hml_pkg::LIM_MAX);
      apb(0, hml_pkg::A_EFFP, 32'h0);
      chk(rd, LIMI);
      chk(limit_warning, 1'b1);
      apb(0, hml_pkg::A_EFFN, 32'h0);
      chk(rd, -LIMI);
      apb(0, 8'h40, 32'h0);
      chk(er, 1'b1);
      lfsr = nx(lfsr);
      t60 = {16'h0, lfsr};
      apb(1, hml_pkg::A_T60, t60);
      lfsr = nx(lfsr);
      t101 = {16'h0, lfsr};
      apb(1, hml_pkg::A_T100, t101);
      apb(1, hml_pkg::A_HSPD, 32'h55);
      apb(1, hml_pkg::A_HACC, 32'h66);
      apb(1, hml_pkg::A_CFG, 32'h4);
      for (int m = 0; m < 10; m++) begin
         lfsr = nx(lfsr);
         refp = {20'h0, lfsr[11:0]};
         lfsr = nx(lfsr);
         ofs = {{20{lfsr[11]}}, lfsr[11:0]};
         src = 3'(m % 4 + 1);
         sel = ends[m % 5];
         apb(1, hml_pkg::A_REFP, refp);
         apb(1, hml_pkg::A_OFS, ofs);
         apb(1, hml_pkg::A_CTRL, {17'h0, lfsr[0], src, sel, 4'(m)});
         mech.pos <= 0;
         apb(1, hml_pkg::A_CMD, 32'h1);
         repeat (3) @(posedge pclk);
         chk({ref_known, homing_busy}, 2'b01);
         chk(move_dir_neg, m[0]);
         chk(homing_speed_out, 32'h55);
         chk(homing_accel_out, 32'h66);
         n = 0;
         while (!pos_load && n < 5000) begin
            @(posedge pclk);
            n++;
         end
         chk({pos_load, end_valid}, 2'b11);
         chk(pos_load_value, refp + ofs);
         chk(end_target, exp_end(sel, refp + ofs));
         chk({ref_known, travel_fault}, 2'b10);
      end
      for (int i = 0; i < 2; i++) begin
         apb(1, i ? hml_pkg::A_LIMN : hml_pkg::A_LIMP, i ? -5000 : 5000);
         mech.pos <= (i ? -5000 : 5000) - ofs;
         repeat (3) @(posedge pclk);
         chk({limit_fault_neg, limit_fault_pos}, 2'b00);
         mech.pos <= (i ? -5001 : 5001) - ofs;
         repeat (3) @(posedge pclk);
         chk({limit_fault_neg, limit_fault_pos, fault_quick_stop},
            i ? 3'b101 : 3'b011);
         mech.pos <= 0;
         apb(1, hml_pkg::A_CMD, 32'h8);
      end
      for (int i = 0; i < 5; i++) begin
         apb(1, hml_pkg::A_CMD, 32'h2);
         repeat (2) @(posedge pclk);
         chk(ref_known, 1'b1);
         clr <= 5'(1 << i);
         @(posedge pclk);
         clr <= 5'h00;
         repeat (2) @(posedge pclk);
         chk(ref_known, 1'b0);
      end
      apb(1, hml_pkg::A_CFG, 32'h1);
      for (int i = 0; i < 2; i++) begin
         apb(1, hml_pkg::A_CMD, 32'h2);
         positioning_active <= i[0];
         prog_reset_in <= 1'b1;
         @(posedge pclk);
         prog_reset_in <= 1'b0;
         repeat (2) @(posedge pclk);
         chk(ref_known, !i[0]);
      end
      for (int i = 0; i < 3; i++) begin
         apb(1, hml_pkg::A_CFG, i == 2 ? 32'h2 : 32'h0);
         {abs_feedback_sel, absolute_accept_input} <=
            i == 2 ? 2'b00 : 2'(i + 1);
         repeat (2) @(posedge pclk);
         chk(ref_known, 1'b1);
         {abs_feedback_sel, absolute_accept_input} <= 2'b00;
      end
      for (int i = 0; i < 3; i++) begin
         apb(1, hml_pkg::A_CMD, 32'h8);
         apb(1, hml_pkg::A_CFG, i == 0 ? 32'h0 : 32'h4);
         apb(1, hml_pkg::A_CTRL, i == 0 ? 32'h2 : i == 1 ? 32'hA : 32'h22);
         apb(1, hml_pkg::A_CMD, 32'h1);
         apb(0, hml_pkg::A_STAT, 32'h0);
         chk({rd[5], homing_busy, ref_known}, 3'b100);
      end
      test_done();
   end
endmodule // homing_and_travel_limits_tb
`default_nettype wire
